// ===== src/asx_top.sv
// Execute datapath for five 8-bit core operations behind an APB slave.
// Assumes an APB master on SYS_CLK; the file register store lies outside.
//
// Overview of operation
// (RL1) Subtract-with-borrow: file minus working minus borrow
// (RL2) Subtract-with-borrow updates carry, half carry, zero
// (RL3) Subtract result to working or file register
// (RL4) Nibble swap exchanges upper and lower nibbles
// (RL5) Swap result to working or file register
// (RL6) Direction load copies working into port A/B/C
// (RL7) Literal XOR into working, zero flag only
// (RL8) File XOR to chosen destination, zero only
// (RL9) Zero flag set exactly when result is zero
`timescale 1ns/1ps
`include "asx_map.svh"
module asx_top
    import asx_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        SRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic      [7:0]  PORT_A_DIRECTION,
    output logic      [7:0]  PORT_B_DIRECTION,
    output logic      [7:0]  PORT_C_DIRECTION,
    output logic             FILE_WE,
    output logic      [6:0]  FILE_ADDR,
    output logic      [7:0]  FILE_WDATA
);

    asx_state_type st;
    asx_state_type next_st;
    logic          access;
    logic          commit;
    logic          exec;
    logic          known;
    logic          read_only;
    logic [31:0]   rdata;

    asx_alu_if alu_bus ();

    asx_alu u_alu (
        .bus (alu_bus.alu)
    );

    // ****************************************
    // Operand steering
    // ****************************************
    assign alu_bus.op       = asx_op_type'(PWDATA[`ASX_CTRL_OP_MSB:`ASX_CTRL_OP_LSB]);
    assign alu_bus.dest     = PWDATA[`ASX_CTRL_DEST];
    assign alu_bus.faddr    = PWDATA[`ASX_CTRL_FA_MSB:`ASX_CTRL_FA_LSB];
    assign alu_bus.literal  = PWDATA[`ASX_CTRL_K_MSB:`ASX_CTRL_K_LSB];
    assign alu_bus.wreg     = st.wreg;
    assign alu_bus.fdata    = st.fdata;
    assign alu_bus.carry_in = st.carry;

    // ****************************************
    // APB decode
    // ****************************************
    // One wait state: pready rises a cycle into access, so reads come from flops
    assign access = PSEL & PENABLE;
    assign commit = access & st.pready;
    assign exec   = commit & PWRITE & ~st.pslverr & (PADDR == `ASX_OFF_CTRL);

    always_comb begin
        rdata     = 32'h0000_0000;
        known     = 1'b1;
        read_only = 1'b0;
        case (PADDR)
            `ASX_OFF_CTRL: begin
                rdata = 32'h0000_0000;
            end
            `ASX_OFF_WREG: begin
                rdata[7:0] = st.wreg;
            end
            `ASX_OFF_FDATA: begin
                rdata[7:0] = st.fdata;
            end
            `ASX_OFF_STATUS: begin
                rdata[`ASX_ST_C]  = st.carry;
                rdata[`ASX_ST_HC] = st.half_carry_flag;
                rdata[`ASX_ST_Z]  = st.zero;
            end
            `ASX_OFF_FRES: begin
                rdata[`ASX_FRES_D_MSB:`ASX_FRES_D_LSB] = st.file_res;
                rdata[`ASX_FRES_A_MSB:`ASX_FRES_A_LSB] = st.file_addr;
                read_only = 1'b1;
            end
            `ASX_OFF_DIR: begin
                rdata[`ASX_DIR_A_MSB:`ASX_DIR_A_LSB] = st.port_a_direction;
                rdata[`ASX_DIR_B_MSB:`ASX_DIR_B_LSB] = st.port_b_direction;
                rdata[`ASX_DIR_C_MSB:`ASX_DIR_C_LSB] = st.port_c_direction;
                read_only = 1'b1;
            end
            default: begin
                known = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_st         = st;
        next_st.file_we = 1'b0;
        if (access && !st.pready) begin
            next_st.pready  = 1'b1;
            next_st.pslverr = ~known | (PWRITE & read_only);
            next_st.prdata  = PWRITE ? 32'h0000_0000 : rdata;
        end else begin
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
        end

        if (commit && PWRITE && !st.pslverr) begin
            case (PADDR)
                `ASX_OFF_WREG: begin
                    next_st.wreg = PWDATA[7:0];
                end
                `ASX_OFF_FDATA: begin
                    next_st.fdata = PWDATA[7:0];
                end
                `ASX_OFF_STATUS: begin
                    next_st.carry           = PWDATA[`ASX_ST_C];
                    next_st.half_carry_flag = PWDATA[`ASX_ST_HC];
                    next_st.zero            = PWDATA[`ASX_ST_Z];
                end
                default: begin
                    next_st.wreg = st.wreg;
                end
            endcase
        end

        if (exec) begin
            if (alu_bus.wr_w) begin
                next_st.wreg = alu_bus.result; // RL3
            end
            // File destination leaves as a pulse; the store itself is outside
            if (alu_bus.wr_f) begin
                next_st.file_we   = 1'b1; // RL3
                next_st.file_addr = alu_bus.faddr;
                next_st.file_res  = alu_bus.result;
            end
            if (alu_bus.upd_c) begin
                next_st.carry = alu_bus.carry; // RL2
            end
            if (alu_bus.upd_hc) begin
                next_st.half_carry_flag = alu_bus.half_carry; // RL2
            end
            if (alu_bus.upd_z) begin
                next_st.zero = alu_bus.zero; // RL9
            end
            if (alu_bus.wr_dir_a) begin
                next_st.port_a_direction = alu_bus.result; // RL6
            end
            if (alu_bus.wr_dir_b) begin
                next_st.port_b_direction = alu_bus.result; // RL6
            end
            if (alu_bus.wr_dir_c) begin
                next_st.port_c_direction = alu_bus.result; // RL6
            end
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // Direction registers reset to all inputs, the safe state for pins
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            st                  <= '0;
            st.wreg             <= `ASX_BYTE_RST;
            st.fdata            <= `ASX_BYTE_RST;
            st.port_a_direction <= `ASX_DIR_RST;
            st.port_b_direction <= `ASX_DIR_RST;
            st.port_c_direction <= `ASX_DIR_RST;
        end else begin
            st <= next_st;
        end
    end

    assign PRDATA           = st.prdata;
    assign PREADY           = st.pready;
    assign PSLVERR          = st.pslverr;
    assign PORT_A_DIRECTION = st.port_a_direction;
    assign PORT_B_DIRECTION = st.port_b_direction;
    assign PORT_C_DIRECTION = st.port_c_direction;
    assign FILE_WE          = st.file_we;
    assign FILE_ADDR        = st.file_addr;
    assign FILE_WDATA       = st.file_res;

endmodule : asx_top

// ===== src/asx_map.svh
// Offsets, field positions, opcode-independent constants and reset values.
// Assumes inclusion by bare name from the top module, the core, the checker and the bench.
`ifndef ASX_MAP_SVH
`define ASX_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ASX_OFF_CTRL     8'h00
`define ASX_OFF_WREG     8'h04
`define ASX_OFF_FDATA    8'h08
`define ASX_OFF_STATUS   8'h0C
`define ASX_OFF_FRES     8'h10
`define ASX_OFF_DIR      8'h14

// ****************************************
// Field positions
// ****************************************
`define ASX_CTRL_OP_LSB  0
`define ASX_CTRL_OP_MSB  2
`define ASX_CTRL_DEST    3
`define ASX_CTRL_FA_LSB  8
`define ASX_CTRL_FA_MSB  14
`define ASX_CTRL_K_LSB   16
`define ASX_CTRL_K_MSB   23
`define ASX_ST_C         0
`define ASX_ST_HC        1
`define ASX_ST_Z         2
`define ASX_FRES_D_LSB   0
`define ASX_FRES_D_MSB   7
`define ASX_FRES_A_LSB   8
`define ASX_FRES_A_MSB   14
`define ASX_DIR_A_LSB    0
`define ASX_DIR_A_MSB    7
`define ASX_DIR_B_LSB    8
`define ASX_DIR_B_MSB    15
`define ASX_DIR_C_LSB    16
`define ASX_DIR_C_MSB    23

// ****************************************
// Operand codes and reset values
// ****************************************
`define ASX_SEL_PORT_A   7'h05
`define ASX_SEL_PORT_B   7'h06
`define ASX_SEL_PORT_C   7'h07
`define ASX_DEST_W       1'b0
`define ASX_BYTE_ZERO    8'h00
`define ASX_DIR_RST      8'hFF
`define ASX_BYTE_RST     8'h00

`endif

// ===== src/asx_pkg.sv
// Types shared by the datapath core, its interface and the top module.
// Assumes asx_map.svh is on the include path.
package asx_pkg;

    // ****************************************
    // Operation select
    // ****************************************
    typedef enum logic [2:0] {
        OP_NONE,
        OP_SUB_FILE_WITH_BORROW,
        OP_NIBBLE_SWAP,
        OP_DIRECTION_LOAD,
        OP_XOR_LITERAL,
        OP_XOR_FILE
    } asx_op_type;

    // ****************************************
    // Top module state
    // ****************************************
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [7:0]  wreg;
        logic [7:0]  fdata;
        logic        carry;
        logic        half_carry_flag;
        logic        zero;
        logic [7:0]  port_a_direction;
        logic [7:0]  port_b_direction;
        logic [7:0]  port_c_direction;
        logic        file_we;
        logic [6:0]  file_addr;
        logic [7:0]  file_res;
    } asx_state_type;

endpackage : asx_pkg

// ===== src/asx_alu_if.sv
// Carrier between the top module and the combinational execute core.
// Assumes asx_pkg is compiled first.
`timescale 1ns/1ps
interface asx_alu_if;
    import asx_pkg::*;
    asx_op_type op;
    logic       dest;
    logic [6:0] faddr;
    logic [7:0] literal;
    logic [7:0] wreg;
    logic [7:0] fdata;
    logic       carry_in;
    logic [7:0] result;
    logic       carry;
    logic       half_carry;
    logic       zero;
    logic       upd_c;
    logic       upd_hc;
    logic       upd_z;
    logic       wr_w;
    logic       wr_f;
    logic       wr_dir_a;
    logic       wr_dir_b;
    logic       wr_dir_c;

    modport core (output op, dest, faddr, literal, wreg, fdata, carry_in,
                  input  result, carry, half_carry, zero, upd_c, upd_hc, upd_z,
                         wr_w, wr_f, wr_dir_a, wr_dir_b, wr_dir_c);
    modport alu  (input  op, dest, faddr, literal, wreg, fdata, carry_in,
                  output result, carry, half_carry, zero, upd_c, upd_hc, upd_z,
                         wr_w, wr_f, wr_dir_a, wr_dir_b, wr_dir_c);
endinterface : asx_alu_if

// ===== src/asx_alu.sv
// Combinational execute core: result, flags and destination enables.
// Assumes the caller registers every output it uses.
`timescale 1ns/1ps
`include "asx_map.svh"
module asx_alu
    import asx_pkg::*;
(
    asx_alu_if.alu bus
);

    logic [8:0] sum9;
    logic [4:0] nib5;

    // Borrow is the inverted carry, so adding carry completes the minus
    always_comb begin
        sum9 = {1'b0, bus.fdata} + {1'b0, ~bus.wreg} + {8'h00, bus.carry_in}; // RL1
        nib5 = {1'b0, bus.fdata[3:0]} + {1'b0, ~bus.wreg[3:0]} + {4'h0, bus.carry_in};
    end

    always_comb begin
        bus.result     = `ASX_BYTE_ZERO;
        bus.carry      = 1'b0;
        bus.half_carry = 1'b0;
        bus.upd_c      = 1'b0;
        bus.upd_hc     = 1'b0;
        bus.upd_z      = 1'b0;
        bus.wr_w       = 1'b0;
        bus.wr_f       = 1'b0;
        bus.wr_dir_a   = 1'b0;
        bus.wr_dir_b   = 1'b0;
        bus.wr_dir_c   = 1'b0;
        case (bus.op)
            OP_SUB_FILE_WITH_BORROW: begin
                bus.result     = sum9[7:0]; // RL1
                bus.carry      = sum9[8];
                bus.half_carry = nib5[4];
                bus.upd_c      = 1'b1; // RL2
                bus.upd_hc     = 1'b1; // RL2
                bus.upd_z      = 1'b1; // RL2
                bus.wr_w       = (bus.dest == `ASX_DEST_W); // RL3
                bus.wr_f       = (bus.dest != `ASX_DEST_W); // RL3
            end
            OP_NIBBLE_SWAP: begin
                bus.result = {bus.fdata[3:0], bus.fdata[7:4]}; // RL4
                bus.wr_w   = (bus.dest == `ASX_DEST_W); // RL5
                bus.wr_f   = (bus.dest != `ASX_DEST_W); // RL5
            end
            OP_DIRECTION_LOAD: begin
                bus.result = bus.wreg; // RL6
                case (bus.faddr)
                    `ASX_SEL_PORT_A: bus.wr_dir_a = 1'b1; // RL6
                    `ASX_SEL_PORT_B: bus.wr_dir_b = 1'b1; // RL6
                    `ASX_SEL_PORT_C: bus.wr_dir_c = 1'b1; // RL6
                    default:         bus.wr_dir_a = 1'b0;
                endcase
            end
            OP_XOR_LITERAL: begin
                bus.result = bus.wreg ^ bus.literal; // RL7
                bus.upd_z  = 1'b1; // RL7
                bus.wr_w   = 1'b1; // RL7
            end
            OP_XOR_FILE: begin
                bus.result = bus.wreg ^ bus.fdata; // RL8
                bus.upd_z  = 1'b1; // RL8
                bus.wr_w   = (bus.dest == `ASX_DEST_W); // RL8
                bus.wr_f   = (bus.dest != `ASX_DEST_W); // RL8
            end
            default: begin
                bus.result = `ASX_BYTE_ZERO;
            end
        endcase
    end

    assign bus.zero = (bus.result == `ASX_BYTE_ZERO); // RL9

endmodule : asx_alu

// ===== dv/asx_top_asserts.sv
// Checker for the execute datapath; watches only the top ports.
// Assumes asx_map.svh on the include path; bound at the foot.
`timescale 1ns/1ps
`include "asx_map.svh"
module asx_top_asserts (
    input wire logic        SYS_CLK,
    input wire logic        SRST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [7:0]  PORT_A_DIRECTION,
    input wire logic [7:0]  PORT_B_DIRECTION,
    input wire logic [7:0]  PORT_C_DIRECTION,
    input wire logic        FILE_WE,
    input wire logic [6:0]  FILE_ADDR,
    input wire logic [7:0]  FILE_WDATA
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    // ***
    // Decode of completed transfers
    // ***
    wire       done  = PSEL && PENABLE && PREADY;
    wire       exec  = done && PWRITE && PADDR == `ASX_OFF_CTRL;
    wire [2:0] op    = PWDATA[2:0];
    wire       to_f  = exec && PWDATA[3] && (op == 3'h1 || op == 3'h2 || op == 3'h5);
    wire       dload = exec && op == 3'h3;
    wire       ro_wr = done && PWRITE && (PADDR == `ASX_OFF_FRES || PADDR == `ASX_OFF_DIR);

    AST_READY_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("access phase not answered after one wait");
    AST_READY_PULSE: assert property (PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");
    AST_FILE_WE: assert property (to_f |=> FILE_WE ##1 !FILE_WE)
        else $error("file write pulse missing or too long");
    AST_FILE_CAUSE: assert property (FILE_WE |-> $past(to_f))
        else $error("file write without a file destination op");
    AST_FILE_ADDR: assert property (to_f |=> FILE_ADDR == $past(PWDATA[14:8]))
        else $error("file write address wrong");
    // Past reset check keeps the reset load of the directions out
    AST_DIR_CAUSE: assert property (!$past(SRST) &&
        !$stable({PORT_A_DIRECTION, PORT_B_DIRECTION, PORT_C_DIRECTION}) |-> $past(dload))
        else $error("direction changed without a direction load");
    AST_DIR_SEL: assert property (dload && PWDATA[14:8] == `ASX_SEL_PORT_A |=>
        $stable(PORT_B_DIRECTION) && $stable(PORT_C_DIRECTION))
        else $error("direction load touched an unselected port");
    AST_RO_REFUSE: assert property (ro_wr |-> PSLVERR)
        else $error("read-only write not refused");
    AST_CTRL_RD0: assert property (done && !PWRITE && PADDR == `ASX_OFF_CTRL |->
        PRDATA == 32'h0 && !PSLVERR)
        else $error("control read not zero");
endmodule : asx_top_asserts

bind asx_top asx_top_asserts u_chk (
    .SYS_CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .PORT_A_DIRECTION, .PORT_B_DIRECTION, .PORT_C_DIRECTION, .FILE_WE,
    .FILE_ADDR, .FILE_WDATA
);

// ===== dv/alu_sub_swap_xor_dirload_tb.sv
// Self-checking bench for the execute datapath, driven over APB.
// Assumes asx_pkg, asx_top and the bound checker are compiled first.
`timescale 1ns/1ps
`include "asx_map.svh"
module alu_sub_swap_xor_dirload_tb;
    logic        SYS_CLK = 1'b0;
    logic        SRST    = 1'b1;
    logic        PSEL    = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE  = 1'b0;
    logic [7:0]  PADDR   = 8'h00;
    logic [31:0] PWDATA  = 32'h0;
    logic [31:0] PRDATA, rdat;
    logic        PREADY, PSLVERR, FILE_WE, rerr;
    logic [7:0]  PORT_A_DIRECTION, PORT_B_DIRECTION, PORT_C_DIRECTION, FILE_WDATA;
    logic [6:0]  FILE_ADDR;
    int          n_fail = 0;
    int          compares = 0;

    asx_top u_dut (.SYS_CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .PORT_A_DIRECTION, .PORT_B_DIRECTION, .PORT_C_DIRECTION,
        .FILE_WE, .FILE_ADDR, .FILE_WDATA);

    initial begin
        forever #4 SYS_CLK = ~SYS_CLK;
    end
    // ***
    // Bus and compare tasks
    // ***
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Ready is taken at the rising edge; the request stands until that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        if (PREADY !== 1'b1) begin
            n_fail++;
            $display("[FAIL] %0t no ready", $time);
            final_report();
        end
        rdat = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask : rd

    task automatic ex(input logic [2:0] op, input logic dst, input logic [6:0] fa,
                      input logic [7:0] k);
        wr(`ASX_OFF_CTRL, {8'h00, k, 1'b0, fa, 4'h0, dst, op});
    endtask : ex

    task automatic fchk(input logic [6:0] fa, input logic [7:0] e);
        @(negedge SYS_CLK);
        chk({16'h0, FILE_WE, FILE_ADDR, FILE_WDATA}, {16'h0, 1'b1, fa, e});
        @(negedge SYS_CLK);
        chk({31'h0, FILE_WE}, 32'h0);
    endtask : fchk
    // ***
    // Scenarios
    // ***
    task automatic t_reset;
        rd(`ASX_OFF_WREG, 32'h0);
        rd(`ASX_OFF_STATUS, 32'h0);
        rd(`ASX_OFF_FRES, 32'h0);
        rd(`ASX_OFF_DIR, 32'h00FF_FFFF);
        rd(`ASX_OFF_CTRL, 32'h0);
    endtask : t_reset

    task automatic t_sub;
        logic [7:0] f [4] = '{8'h05, 8'h10, 8'h03, 8'h03};
        logic [7:0] w [4] = '{8'h03, 8'h01, 8'h03, 8'h02};
        logic       c [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        logic [8:0] s;
        logic [4:0] h;
        for (int i = 0; i < 4; i++) begin
            // Borrow shows as the top bit of a plain difference
            s = {1'b0, f[i]} - {1'b0, w[i]} - {8'h00, ~c[i]};
            h = {1'b0, f[i][3:0]} - {1'b0, w[i][3:0]} - {4'h0, ~c[i]};
            wr(`ASX_OFF_WREG, {24'h0, w[i]});
            wr(`ASX_OFF_FDATA, {24'h0, f[i]});
            wr(`ASX_OFF_STATUS, {31'h0, c[i]});
            ex(3'h1, 1'b0, 7'h7F, 8'h00);
            rd(`ASX_OFF_WREG, {24'h0, s[7:0]});
            rd(`ASX_OFF_STATUS, {29'h0, s[7:0] == 8'h00, ~h[4], ~s[8]});
        end
        wr(`ASX_OFF_STATUS, 32'h0);
        ex(3'h1, 1'b1, 7'h7F, 8'h00);
        fchk(7'h7F, 8'h02);
        rd(`ASX_OFF_WREG, 32'h0);
    endtask : t_sub

    task automatic t_swap;
        wr(`ASX_OFF_FDATA, 32'h0000_00A5);
        wr(`ASX_OFF_STATUS, 32'h0000_0007);
        ex(3'h2, 1'b0, 7'h00, 8'h00);
        rd(`ASX_OFF_WREG, 32'h0000_005A);
        rd(`ASX_OFF_STATUS, 32'h0000_0007);
        ex(3'h2, 1'b1, 7'h00, 8'h00);
        fchk(7'h00, 8'h5A);
    endtask : t_swap

    task automatic t_dir;
        logic [31:0] e = 32'h00FF_FFFF;
        for (int i = 0; i < 3; i++) begin
            e[8*i +: 8] = 8'h11 << i;
            wr(`ASX_OFF_WREG, {24'h0, e[8*i +: 8]});
            ex(3'h3, 1'b0, 7'(5 + i), 8'h00);
            rd(`ASX_OFF_DIR, e);
            chk({8'h0, PORT_C_DIRECTION, PORT_B_DIRECTION, PORT_A_DIRECTION}, e);
        end
        ex(3'h3, 1'b0, 7'h04, 8'h00);
        rd(`ASX_OFF_DIR, e);
        rd(`ASX_OFF_STATUS, 32'h0000_0007);
    endtask : t_dir

    task automatic t_xor;
        wr(`ASX_OFF_WREG, 32'h0000_00F0);
        wr(`ASX_OFF_STATUS, 32'h0000_0003);
        ex(3'h4, 1'b1, 7'h00, 8'hF0);
        rd(`ASX_OFF_WREG, 32'h0);
        rd(`ASX_OFF_STATUS, 32'h0000_0007);
        ex(3'h4, 1'b0, 7'h00, 8'h0F);
        rd(`ASX_OFF_WREG, 32'h0000_000F);
        rd(`ASX_OFF_STATUS, 32'h0000_0003);
        wr(`ASX_OFF_FDATA, 32'h0000_000F);
        ex(3'h5, 1'b0, 7'h00, 8'h00);
        rd(`ASX_OFF_WREG, 32'h0);
        rd(`ASX_OFF_STATUS, 32'h0000_0007);
        wr(`ASX_OFF_FDATA, 32'h0000_00AA);
        wr(`ASX_OFF_WREG, 32'h0000_000F);
        ex(3'h5, 1'b1, 7'h2A, 8'h00);
        fchk(7'h2A, 8'hA5);
        rd(`ASX_OFF_WREG, 32'h0000_000F);
        rd(`ASX_OFF_STATUS, 32'h0000_0003);
    endtask : t_xor

    task automatic t_err;
        wr(`ASX_OFF_FRES, 32'h0000_FFFF);
        chk({31'h0, rerr}, 32'h1);
        rd(`ASX_OFF_FRES, 32'h0000_2AA5);
        wr(`ASX_OFF_DIR, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        rd(`ASX_OFF_DIR, 32'h0044_2211);
        rd(8'h18, 32'h0);
        chk({31'h0, rerr}, 32'h1);
    endtask : t_err

    // Codes 0, 6 and 7 must leave every register alone
    task automatic t_nop;
        wr(`ASX_OFF_WREG, 32'h0000_003C);
        wr(`ASX_OFF_STATUS, 32'h0000_0005);
        for (int i = 0; i < 3; i++) begin
            ex(3'((i == 0) ? 0 : i + 5), 1'b1, 7'h05, 8'hFF);
        end
        rd(`ASX_OFF_WREG, 32'h0000_003C);
        rd(`ASX_OFF_STATUS, 32'h0000_0005);
        rd(`ASX_OFF_FRES, 32'h0000_2AA5);
        rd(`ASX_OFF_DIR, 32'h0044_2211);
    endtask : t_nop

    // Reset again in mid-run, with every register but the half carry flag away from its reset value
    task automatic t_rerun;
        @(posedge SYS_CLK);
        SRST <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        SRST <= 1'b0;
        t_reset();
    endtask : t_rerun

    initial begin
        repeat (2) @(posedge SYS_CLK);
        SRST <= 1'b0;
        t_reset();
        t_sub();
        t_swap();
        t_dir();
        t_xor();
        t_err();
        t_nop();
        t_rerun();
        final_report();
    end
endmodule : alu_sub_swap_xor_dirload_tb
